// ### design/sss_pkg.sv
// constants, register map and types of the shutter strobe generator
package sss_pkg;
  // sensor timing clock
  localparam int unsigned CLK_MHZ   = 125;
  localparam int unsigned US_CYC    = CLK_MHZ;  // cycles per microsecond
  // line stagger per variant, in microseconds and in cycles (rounded up)
  localparam real         LS_LO_US  = 29.479166;
  localparam real         LS_HI_US  = 36.145833;
  localparam int unsigned LS_LO_CYC = int'($ceil(LS_LO_US * CLK_MHZ));
  localparam int unsigned LS_HI_CYC = int'($ceil(LS_HI_US * CLK_MHZ));
  // lines added to the region height to form the sensor height
  localparam logic [12:0] EXTRA_LINES = 13'h0008;
  // widths
  localparam int unsigned LINE_W = 13;
  localparam int unsigned US_W   = 16;
  localparam int unsigned EXP_W  = 20;
  localparam int unsigned HGT_W  = 12;
  localparam int unsigned PORTS  = 4;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DELAY  = 8'h04;
  localparam logic [7:0] OFS_DUR    = 8'h08;
  localparam logic [7:0] OFS_EXPO   = 8'h0C;
  localparam logic [7:0] OFS_HEIGHT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // control fields
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_ROLL_BIT = 1;
  localparam int unsigned CTRL_MODE_BIT = 2;
  localparam int unsigned CTRL_PORT_LSB = 4;
  // status fields
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_WIN_BIT   = 1;
  localparam int unsigned STAT_STRB_BIT  = 2;
  localparam int unsigned STAT_NOWIN_BIT = 3;
  localparam int unsigned STAT_CNT_LSB   = 16;
  // reset values
  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [15:0] RST_DELAY  = 16'h0000;
  localparam logic [15:0] RST_DUR    = 16'h0064;
  localparam logic [19:0] RST_EXPO   = 20'h02710;
  localparam logic [11:0] RST_HEIGHT = 12'h400;
  // frame phase
  typedef enum logic [1:0] {
    SSS_PH_IDLE = 2'b01,
    SSS_PH_RUN  = 2'b10
  } sss_phase_e;
endpackage

// ### design/sss_line_seq.sv
// steps a line index once per line stagger interval after a start pulse
`timescale 1ns/10ps
module sss_line_seq (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        go_in,
  input  wire logic [12:0] stagger_in,
  input  wire logic [12:0] lines_in,
  output logic             pulse_out,
  output logic [12:0]      idx_out,
  output logic             busy_out
);
  typedef struct packed {
    logic        busy;
    logic        pulse;
    logic [12:0] cnt;
    logic [12:0] idx;
    logic [12:0] last;
    logic [12:0] stg;
  } sss_seq_s;

  sss_seq_s s_reg;
  sss_seq_s s_next;

  // start line 0 on go, then one line per stagger interval
  always_comb
  begin
    s_next       = s_reg;
    s_next.pulse = 1'b0;
    if (go_in)
    begin
      s_next.pulse = 1'b1;
      s_next.idx   = 13'h0000;
      s_next.cnt   = 13'h0000;
      s_next.last  = lines_in - 13'h0001;
      s_next.stg   = stagger_in;
      s_next.busy  = (lines_in > 13'h0001);
    end
    else if (s_reg.busy)
    begin
      if (s_reg.cnt == s_reg.stg - 13'h0001)
      begin
        s_next.cnt   = 13'h0000;
        s_next.idx   = s_reg.idx + 13'h0001;
        s_next.pulse = 1'b1;
        s_next.busy  = (s_reg.idx + 13'h0001 != s_reg.last);
      end
      else
      begin
        s_next.cnt = s_reg.cnt + 13'h0001;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign pulse_out = s_reg.pulse;
  assign idx_out   = s_reg.idx;
  assign busy_out  = s_reg.busy;

  // checker helper: cycles since the last pulse
  logic [12:0] gap_reg;
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      gap_reg <= 13'h0000;
    else if (s_reg.pulse)
      gap_reg <= 13'h0001;
    else
      gap_reg <= gap_reg + 13'h0001;
  end

  a_line_spacing: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (s_reg.pulse && !$past(go_in) && s_reg.idx != 13'h0000) |-> (gap_reg == s_reg.stg))
    else $error("line start spacing differs from the stagger interval");
  a_last_line: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ($fell(s_reg.busy) && !$past(go_in)) |-> (s_reg.pulse && s_reg.idx == s_reg.last))
    else $error("sequence stopped before the bottom line");
endmodule

// ### design/sss_strobe_gen.sv
// shutter strobe generator: exposure timing, window and strobe outputs, register slave
//
// Functional notes
// - global shutter starts and ends every line in one cycle per frame.
// - global shutter exposure indication is high exactly over the exposure period.
// - rolling shutter starts top line on trigger, then each line one stagger later.
// - rolling shutter exposes every line for the same configured exposure time.
// - sensor height equals region height plus eight lines.
// - window opens stagger times (height minus one) after the trigger.
// - window stays open exposure minus stagger times (height minus one).
// - no window strobe at all when exposure is not longer than that product.
// - window strobe never outside window; delay and duration only shorten it.
// - window strobe mode drives the strobe on the selected output port.
// - stagger is 29.479166 us on lower variants, 36.145833 us on highest.
// - rolling whole-exposure mode: high from first row start to last row end.
// - rolling whole-exposure mode ignores strobe delay and duration.
// - adjustable modes delay the strobe after capture start by the delay in us.
// - adjustable modes hold the strobe for the duration in us unless cut short.
`timescale 1ns/10ps
module sss_strobe_gen #(
  parameter int unsigned LS_LO_CYC = sss_pkg::LS_LO_CYC,
  parameter int unsigned LS_HI_CYC = sss_pkg::LS_HI_CYC,
  parameter bit          HIGH_RES  = 1'b0
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        FRAME_TRIG_IN,
  output logic             STROBE_OUT,
  output logic [3:0]       STROBE_PORT_OUT,
  output logic             EXPO_ACTIVE_OUT,
  output logic             WINDOW_OUT,
  output logic             ALL_LINES_START_OUT,
  output logic             ALL_LINES_END_OUT,
  output logic             LINE_START_OUT,
  output logic [12:0]      LINE_START_IDX_OUT,
  output logic             LINE_END_OUT,
  output logic [12:0]      LINE_END_IDX_OUT,
  output logic             FRAME_BUSY_OUT
);
  // fixed per-variant line stagger in cycles
  localparam logic [12:0] STAGGER = HIGH_RES ? 13'(LS_HI_CYC) : 13'(LS_LO_CYC);

  typedef struct packed {
    logic                wr_pend;
    logic [7:0]          addr;
    logic [31:0]         hrdata;
    logic                en;
    logic                roll_cfg;
    logic                mode_cfg;
    logic [1:0]          port_sel;
    logic [15:0]         delay_us;
    logic [15:0]         dur_us;
    logic [19:0]         expo_us;
    logic [11:0]         height;
    sss_pkg::sss_phase_e phase;
    logic                roll;
    logic                mode_expo;
    logic [31:0]         t;
    logic [31:0]         open_cyc;
    logic [31:0]         exp_cyc;
    logic [31:0]         end_cyc;
    logic [31:0]         dly_cyc;
    logic [31:0]         dend_cyc;
    logic                no_win;
    logic [12:0]         lines;
    logic [15:0]         frames;
    logic                strobe;
    logic [3:0]          ports;
    logic                expo;
    logic                win;
    logic                all_start;
    logic                all_end;
  } sss_state_s;

  sss_state_s s_reg;
  sss_state_s s_next;

  logic        addr_phase;
  logic        go_start;
  logic        go_end;
  logic        run_n;
  logic        pls_n;
  logic [12:0] lines_cfg;
  logic        ls_pulse;
  logic [12:0] ls_idx;
  logic        le_pulse;
  logic [12:0] le_idx;

  // truncating 32-bit product, shared by all timing figures
  function automatic logic [31:0] mul32(input logic [31:0] a, input logic [31:0] b);
    mul32 = 32'(a * b);
  endfunction

  // register read value at a byte offset
  function automatic logic [31:0] rd_word(input sss_state_s r, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      sss_pkg::OFS_CTRL:
      begin
        w[sss_pkg::CTRL_EN_BIT]                          = r.en;
        w[sss_pkg::CTRL_ROLL_BIT]                        = r.roll_cfg;
        w[sss_pkg::CTRL_MODE_BIT]                        = r.mode_cfg;
        w[sss_pkg::CTRL_PORT_LSB +: 2]                   = r.port_sel;
      end
      sss_pkg::OFS_DELAY:  w[15:0] = r.delay_us;
      sss_pkg::OFS_DUR:    w[15:0] = r.dur_us;
      sss_pkg::OFS_EXPO:   w[19:0] = r.expo_us;
      sss_pkg::OFS_HEIGHT: w[11:0] = r.height;
      sss_pkg::OFS_STATUS:
      begin
        w[sss_pkg::STAT_BUSY_BIT]       = (r.phase == sss_pkg::SSS_PH_RUN);
        w[sss_pkg::STAT_WIN_BIT]        = r.win;
        w[sss_pkg::STAT_STRB_BIT]       = r.strobe;
        w[sss_pkg::STAT_NOWIN_BIT]      = r.no_win;
        w[sss_pkg::STAT_CNT_LSB +: 16]  = r.frames;
      end
      default: w = 32'h00000000;
    endcase
    rd_word = w;
  endfunction

  // sensor height from the region height
  assign lines_cfg  = {1'b0, s_reg.height} + sss_pkg::EXTRA_LINES;
  assign addr_phase = HSEL_IN && HREADY_IN && HTRANS_IN[1];

  // bus slave, frame timer and output shaping
  always_comb
  begin
    s_next   = s_reg;
    go_start = 1'b0;
    go_end   = 1'b0;
    // data phase of a write
    if (s_reg.wr_pend)
    begin
      case (s_reg.addr)
        sss_pkg::OFS_CTRL:
        begin
          s_next.en       = HWDATA_IN[sss_pkg::CTRL_EN_BIT];
          s_next.roll_cfg = HWDATA_IN[sss_pkg::CTRL_ROLL_BIT];
          s_next.mode_cfg = HWDATA_IN[sss_pkg::CTRL_MODE_BIT];
          s_next.port_sel = HWDATA_IN[sss_pkg::CTRL_PORT_LSB +: 2];
        end
        sss_pkg::OFS_DELAY:  s_next.delay_us = HWDATA_IN[15:0];
        sss_pkg::OFS_DUR:    s_next.dur_us   = HWDATA_IN[15:0];
        sss_pkg::OFS_EXPO:   s_next.expo_us  = HWDATA_IN[19:0];
        sss_pkg::OFS_HEIGHT: s_next.height   = HWDATA_IN[11:0];
        default: ;
      endcase
    end
    // address phase: remember writes, answer reads with post-write values
    s_next.wr_pend = 1'b0;
    if (addr_phase)
    begin
      s_next.addr    = {HADDR_IN[7:2], 2'b00};
      s_next.wr_pend = HWRITE_IN;
      if (!HWRITE_IN)
        s_next.hrdata = rd_word(s_next, {HADDR_IN[7:2], 2'b00});
    end
    // frame timer
    case (s_reg.phase)
      sss_pkg::SSS_PH_IDLE:
      begin
        if (FRAME_TRIG_IN && s_reg.en)
        begin
          s_next.phase     = sss_pkg::SSS_PH_RUN;
          s_next.t         = 32'h00000000;
          s_next.roll      = s_reg.roll_cfg;
          s_next.mode_expo = s_reg.mode_cfg;
          s_next.lines     = lines_cfg;
          // global: all lines together, so the window offset is zero
          s_next.open_cyc  = s_reg.roll_cfg ? mul32(32'(STAGGER), 32'(lines_cfg - 13'h0001)) : 32'h00000000;
          s_next.exp_cyc   = mul32(32'(s_reg.expo_us), sss_pkg::US_CYC);
          s_next.end_cyc   = s_next.open_cyc + s_next.exp_cyc;
          s_next.dly_cyc   = mul32(32'(s_reg.delay_us), sss_pkg::US_CYC);
          s_next.dend_cyc  = mul32(32'(s_reg.delay_us) + 32'(s_reg.dur_us), sss_pkg::US_CYC);
          s_next.no_win    = !(s_next.exp_cyc > s_next.open_cyc);
          s_next.frames    = s_reg.frames + 16'h0001;
          go_start         = s_reg.roll_cfg;
        end
      end
      sss_pkg::SSS_PH_RUN:
      begin
        s_next.t = s_reg.t + 32'h00000001;
        if (s_reg.t == s_reg.end_cyc)
        begin
          s_next.phase = sss_pkg::SSS_PH_IDLE;
          s_next.t     = s_reg.t;
        end
        // line 0 ends one exposure after it started; others follow at stagger
        go_end = s_reg.roll && (s_reg.t + 32'h00000001 == s_reg.exp_cyc) && (s_reg.t != s_reg.end_cyc);
      end
      default: s_next.phase = sss_pkg::SSS_PH_IDLE;
    endcase
    // outputs follow the timer value being registered
    run_n = (s_next.phase == sss_pkg::SSS_PH_RUN);
    pls_n = run_n && (s_next.t >= s_next.dly_cyc) && (s_next.t < s_next.dend_cyc);
    s_next.expo = run_n && (s_next.t < s_next.end_cyc);
    s_next.win  = run_n && s_next.roll && !s_next.no_win
                  && (s_next.t >= s_next.open_cyc) && (s_next.t < s_next.exp_cyc);
    if (s_next.roll && s_next.mode_expo)
      s_next.strobe = s_next.expo;  // fixed timing, delay/duration unused
    else if (s_next.roll)
      s_next.strobe = s_next.win && pls_n;
    else
      s_next.strobe = s_next.expo && pls_n;  // global adjustable strobe
    s_next.ports     = s_next.strobe ? (4'h1 << s_next.port_sel) : 4'h0;
    s_next.all_start = run_n && !s_next.roll && (s_reg.phase == sss_pkg::SSS_PH_IDLE);
    s_next.all_end   = run_n && !s_next.roll && (s_next.t == s_next.exp_cyc);
  end

  // state register
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      s_reg          <= '0;
      s_reg.en       <= sss_pkg::RST_CTRL[sss_pkg::CTRL_EN_BIT];
      s_reg.roll_cfg <= sss_pkg::RST_CTRL[sss_pkg::CTRL_ROLL_BIT];
      s_reg.mode_cfg <= sss_pkg::RST_CTRL[sss_pkg::CTRL_MODE_BIT];
      s_reg.port_sel <= sss_pkg::RST_CTRL[sss_pkg::CTRL_PORT_LSB +: 2];
      s_reg.delay_us <= sss_pkg::RST_DELAY;
      s_reg.dur_us   <= sss_pkg::RST_DUR;
      s_reg.expo_us  <= sss_pkg::RST_EXPO;
      s_reg.height   <= sss_pkg::RST_HEIGHT;
      s_reg.phase    <= sss_pkg::SSS_PH_IDLE;
    end
    else
      s_reg <= s_next;
  end

  // line start and line end sequencers for the rolling shutter
  sss_line_seq u_start_seq (
    .clk_in     (CLK_SYS_IN),
    .arst_n_in  (ARST_N_IN),
    .go_in      (go_start),
    .stagger_in (STAGGER),
    .lines_in   (lines_cfg),
    .pulse_out  (ls_pulse),
    .idx_out    (ls_idx),
    .busy_out   ()
  );

  sss_line_seq u_end_seq (
    .clk_in     (CLK_SYS_IN),
    .arst_n_in  (ARST_N_IN),
    .go_in      (go_end),
    .stagger_in (STAGGER),
    .lines_in   (s_reg.lines),
    .pulse_out  (le_pulse),
    .idx_out    (le_idx),
    .busy_out   ()
  );

  // port drive
  assign HRDATA_OUT          = s_reg.hrdata;
  assign HREADYOUT_OUT       = 1'b1;
  assign HRESP_OUT           = 1'b0;
  assign STROBE_OUT          = s_reg.strobe;
  assign STROBE_PORT_OUT     = s_reg.ports;
  assign EXPO_ACTIVE_OUT     = s_reg.expo;
  assign WINDOW_OUT          = s_reg.win;
  assign ALL_LINES_START_OUT = s_reg.all_start;
  assign ALL_LINES_END_OUT   = s_reg.all_end;
  assign LINE_START_OUT      = ls_pulse;
  assign LINE_START_IDX_OUT  = ls_idx;
  assign LINE_END_OUT        = le_pulse;
  assign LINE_END_IDX_OUT    = le_idx;
  assign FRAME_BUSY_OUT      = (s_reg.phase == sss_pkg::SSS_PH_RUN);

  // checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);

  sequence trig_taken;
    (s_reg.phase == sss_pkg::SSS_PH_IDLE) && FRAME_TRIG_IN && s_reg.en;
  endsequence
  sequence global_frame;
    trig_taken ##0 !s_reg.roll_cfg;
  endsequence

  a_global_start: assert property (
    global_frame |=> (ALL_LINES_START_OUT && EXPO_ACTIVE_OUT && s_reg.t == 32'h00000000))
    else $error("global frame did not start all lines at once");
  a_global_end: assert property (
    (ALL_LINES_END_OUT && s_reg.exp_cyc != 32'h00000000) |-> ($past(EXPO_ACTIVE_OUT) && !EXPO_ACTIVE_OUT))
    else $error("global exposure indication not ending with the exposure");
  a_roll_first_line: assert property (
    (trig_taken ##0 s_reg.roll_cfg) |=> (LINE_START_OUT && LINE_START_IDX_OUT == 13'h0000))
    else $error("rolling frame did not start the top line");
  a_line_expo_equal: assert property (
    (LINE_END_OUT && LINE_END_IDX_OUT == 13'h0000) |-> (s_reg.t == s_reg.exp_cyc))
    else $error("top line exposure length differs from the setting");
  a_height_plus8: assert property (
    trig_taken |=> (s_reg.lines == $past(lines_cfg) && s_reg.lines == {1'b0, $past(s_reg.height)} + 13'h0008))
    else $error("sensor height not region height plus eight");
  a_window_open: assert property (
    $rose(WINDOW_OUT) |-> (s_reg.t == s_reg.open_cyc))
    else $error("window opened at the wrong time");
  a_window_close: assert property (
    ($fell(WINDOW_OUT) && FRAME_BUSY_OUT) |-> (s_reg.t == s_reg.exp_cyc))
    else $error("window closed at the wrong time");
  a_no_window: assert property (
    (s_reg.no_win && s_reg.roll) |-> (!WINDOW_OUT && !(STROBE_OUT && !s_reg.mode_expo)))
    else $error("window strobe asserted although exposure is too short");
  a_strobe_inside: assert property (
    (STROBE_OUT && s_reg.roll && !s_reg.mode_expo) |-> WINDOW_OUT)
    else $error("window strobe outside the window");
  a_port_select: assert property (
    STROBE_PORT_OUT == (STROBE_OUT ? (4'h1 << s_reg.port_sel) : 4'h0))
    else $error("strobe not on the selected port");
  a_whole_expo: assert property (
    (FRAME_BUSY_OUT && s_reg.roll && s_reg.mode_expo) |-> (STROBE_OUT == (s_reg.t < s_reg.end_cyc)))
    else $error("whole-exposure strobe does not span first start to last end");
  a_delay_start: assert property (
    ($rose(STROBE_OUT) && !(s_reg.roll && s_reg.mode_expo)) |-> (s_reg.t >= s_reg.dly_cyc))
    else $error("strobe rose before the configured delay");
  a_duration_end: assert property (
    (STROBE_OUT && !(s_reg.roll && s_reg.mode_expo)) |-> (s_reg.t < s_reg.dend_cyc))
    else $error("strobe held past the configured duration");
  a_global_span: assert property (
    (FRAME_BUSY_OUT && !s_reg.roll) |-> (EXPO_ACTIVE_OUT == (s_reg.t < s_reg.exp_cyc)))
    else $error("global exposure indication outside the exposure period");
  a_window_span: assert property (
    WINDOW_OUT |-> (FRAME_BUSY_OUT && s_reg.t >= s_reg.open_cyc && s_reg.t < s_reg.exp_cyc))
    else $error("window open outside its computed span");
  a_expo_fixed: assert property (
    (FRAME_BUSY_OUT && s_reg.roll && s_reg.mode_expo && s_reg.t == 32'h00000000) |-> STROBE_OUT)
    else $error("whole-exposure strobe does not start with the first row");
  a_strobe_at_delay: assert property (
    (FRAME_BUSY_OUT && !s_reg.roll && s_reg.t == s_reg.dly_cyc && s_reg.t < s_reg.exp_cyc
     && s_reg.dly_cyc < s_reg.dend_cyc) |-> STROBE_OUT)
    else $error("global strobe not active once the delay has passed");
endmodule

// ### test/sss_lamp_model.sv
// strobe lamp model: counts flashes seen on any strobe port line
`timescale 1ns/10ps
module sss_lamp_model (
  input  wire logic       clk_in,
  input  wire logic [3:0] drive_in,
  output int              flashes_out
);
  logic lit_reg = 1'b0;
  // a flash is a rising edge of the lamp drive
  always @(posedge clk_in)
  begin
    if ((|drive_in) === 1'b1 && !lit_reg) flashes_out <= flashes_out + 1;
    lit_reg <= ((|drive_in) === 1'b1);
  end
endmodule

// ### test/tb.sv
// self-checking bench of the shutter strobe generator
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t: got %0h want %0h", $time, (a), (b)); end end
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hready, hresp, trig = 1'b0;
  logic        stb, expo, win, als, ale, ls, le, busy;
  logic [3:0]  sport;
  logic [12:0] lsi, lei;
  int          n_errors = 0;
  int          n_tests = 0;
  int          t, m_exp, m_win, m_stb, m_first, m_ls, m_le, m_all, m_bad, f0;
  int          cur_e, cur_p, flashes;
  bit          cur_wm;
  // ctrl, height, expo us, delay us, dur us | expo, window, strobe, first strobe, lines, global pulses, flashes
  int rows [7][12] = '{
    '{'h01, 2, 1, 0, 1, 125, 0, 125, 0, 0, 2, 1},
    '{'h11, 2, 2, 1, 3, 250, 0, 125, 125, 0, 2, 1},
    '{'h23, 2, 1, 0, 1, 197, 53, 53, 72, 10, 0, 1},
    '{'h03, 2, 2, 1, 1, 322, 178, 125, 125, 10, 0, 1},
    '{'h37, 2, 1, 5, 1, 197, 53, 197, 0, 10, 0, 1},
    '{'h25, 2, 2, 1, 1, 250, 0, 125, 125, 0, 2, 1},
    '{'h23, 20, 1, 0, 1, 341, 0, 0, -1, 28, 0, 0}};

  // 125 MHz clock
  always #4 clk = ~clk;

  sss_strobe_gen #(.LS_LO_CYC(8), .LS_HI_CYC(8), .HIGH_RES(1'b0)) DUT (
    .CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .FRAME_TRIG_IN(trig), .STROBE_OUT(stb),
    .STROBE_PORT_OUT(sport), .EXPO_ACTIVE_OUT(expo), .WINDOW_OUT(win), .ALL_LINES_START_OUT(als),
    .ALL_LINES_END_OUT(ale), .LINE_START_OUT(ls), .LINE_START_IDX_OUT(lsi), .LINE_END_OUT(le),
    .LINE_END_IDX_OUT(lei), .FRAME_BUSY_OUT(busy));

  sss_lamp_model lamp (.clk_in(clk), .drive_in(sport), .flashes_out(flashes));

  // per-frame measurement, t counts cycles since busy rose
  always @(negedge clk)
  if (busy === 1'b1)
  begin
    if (stb === 1'b1 && m_first < 0) m_first = t;
    m_exp += (expo === 1'b1);
    m_win += (win === 1'b1);
    m_stb += (stb === 1'b1);
    m_ls += (ls === 1'b1);
    m_le += (le === 1'b1);
    m_all += (als === 1'b1) + (ale === 1'b1);
    if (ls === 1'b1 && t !== 8 * lsi) m_bad++;
    if (le === 1'b1 && t !== cur_e + 8 * lei) m_bad++;
    if ((als === 1'b1 && t !== 0) || (ale === 1'b1 && t !== cur_e)) m_bad++;
    if (cur_wm && stb === 1'b1 && win !== 1'b1) m_bad++;
    if (sport !== (stb === 1'b1 ? 4'h1 << cur_p : 4'h0)) m_bad++;
    t++;
  end

  // one single AHB transfer, waiting on hready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  // trigger held for n edges, then wait for the frame to finish
  task automatic frame(input int n);
    m_exp = 0; m_win = 0; m_stb = 0; m_ls = 0; m_le = 0; m_all = 0; m_bad = 0;
    t = 0;
    m_first = -1;
    f0 = flashes;
    @(posedge clk);
    trig <= 1'b1;
    repeat (n) @(posedge clk);
    trig <= 1'b0;
    for (int w = 0; w < 6000 && !(t > 0 && busy === 1'b0); w++) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog: all frames and bus traffic fit well inside 50k cycles
  initial
  begin
    #400000;
    n_errors++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    `CHK({busy, stb, expo, hready}, 4'h1)
    rst_n <= 1'b1;
    `CHK(sss_pkg::LS_LO_CYC, 3685)
    `CHK(sss_pkg::LS_HI_CYC, 4519)
    // table of frames; exposure always set by hand
    for (int i = 0; i < 7; i++)
    begin
      ahb(1'b1, 32'h04, rows[i][3]);
      ahb(1'b1, 32'h08, rows[i][4]);
      ahb(1'b1, 32'h0C, rows[i][2]);
      ahb(1'b1, 32'h10, rows[i][1]);
      ahb(1'b1, 32'h00, rows[i][0]);
      cur_e = rows[i][2] * 125;
      cur_p = (rows[i][0] >> 4) & 3;
      cur_wm = ((rows[i][0] & 6) == 2);
      frame(1);
      `CHK(m_exp, rows[i][5])
      `CHK(m_win, rows[i][6])
      `CHK(m_stb, rows[i][7])
      `CHK(m_first, rows[i][8])
      `CHK(m_ls, rows[i][9])
      `CHK(m_le, rows[i][9])
      `CHK(m_all, rows[i][10])
      `CHK(flashes - f0, rows[i][11])
      `CHK(m_bad, 0)
    end
    // trigger held into a running frame starts only one frame
    frame(3);
    `CHK(m_exp, 341)
    ahb(1'b0, 32'h14, 32'h0);
    `CHK(rd[31:16], 16'h0008)
    `CHK(rd[3:0], 4'h8)
    // disabled block ignores the trigger
    ahb(1'b1, 32'h00, 32'h00);
    frame(1);
    `CHK(t, 0)
    // reset in mid-frame clears outputs and returns the control, duration, exposure and height registers to their reset values
    ahb(1'b1, 32'h00, 32'h01);
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    `CHK({busy, expo, stb, sport}, 7'h00)
    @(posedge clk);
    rst_n <= 1'b1;
    ahb(1'b0, 32'h00, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'b0, 32'h08, 32'h0);
    `CHK(rd, 32'h64)
    ahb(1'b0, 32'h0C, 32'h0);
    `CHK(rd, 32'h2710)
    ahb(1'b0, 32'h10, 32'h0);
    `CHK(rd, 32'h400)
    ahb(1'b0, 32'h18, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(hresp, 1'b0)
    tally_and_finish();
  end
endmodule
